// File: design/cbs_bus_watch.sv
// Receive pin synchroniser, falling edge detector, recessive bit counter.
// Assumes i_bit_tick is a one-cycle pulse at each bit sample point.
`timescale 1ns/1ps
`include "cbs_consts.svh"
module cbs_bus_watch #(
  parameter int RJ_BITS = `CBS_REJOIN_BITS
) (
  input  wire logic i_mclk,      // Module clock
  input  wire logic i_rst_n,     // Synchronised reset, active low
  input  wire logic i_rx_pin,    // Receive pin, asynchronous
  input  wire logic i_bit_tick,  // Bit sample pulse
  input  wire logic i_restart,   // Restart recessive count
  output logic      o_fall,      // Recessive to dominant pulse
  output logic      o_idle_run   // Enough recessive bits seen
);
  logic                  rx_meta_q;
  logic                  rx_sync_q;
  logic                  rx_prev_q;
  logic [`CBS_CNT_W-1:0] rcnt_q;

  // Two flops before any logic looks at the pin
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= i_rx_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  assign o_fall = rx_prev_q & ~rx_sync_q;

  // Consecutive recessive bits; a dominant bit starts over
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rcnt_q <= '0;
    end else if (i_restart || (i_bit_tick && !rx_sync_q)) begin
      rcnt_q <= '0;
    end else if (i_bit_tick && (rcnt_q != RJ_BITS[`CBS_CNT_W-1:0])) begin
      rcnt_q <= rcnt_q + 1'b1;
    end
  end

  assign o_idle_run = (rcnt_q == RJ_BITS[`CBS_CNT_W-1:0]);
endmodule

// File: design/cbs_ctrl.sv
// Block transmit abort/resume control and sleep/stop power-save control.
// Assumes bus timing, buffers and frame engine sit outside on i_mclk.
// Summary of operation
// R1: Trigger stays set until on-bus frame ends
// R2: Successful last frame: pointer moves to next
// R3: Error with request still set: pointer stays
// R4: Error with request clear: pointer advances
// R5: Software aborts only by clearing trigger
// R6: Abort on final buffer success is completion
// R7: Resume with next buffer unready ends immediately
// R8: Remote bit on transmit buffer sends remote
// R9: Sleep release restores the requesting mode
// R10: No transmission starts while asleep
// R11: Writing 01 to power-save field requests sleep
// R12: Sleep granted only at idle, nothing pending
// R13: Pending sleep survives traffic, enters after storage
// R14: Sleep in init ignored; init in sleep ignored
// R15: Field reads 00 until sleep entered
// R16: Initialization request overrides sleep request
// R17: Sleep stops clock, watches pin, drops access
// R18: Asleep only power-save field writable
// R19: Leave sleep on 00 write or falling edge
// R20: Waking frame dropped; gated clock blocks wake
// R21: Bus wake sets wakeup flag unconditionally
// R22: Rejoin after 11 recessive bits
// R23: Stop request accepted only while asleep
// R24: Flag and enable raise wakeup interrupt
`timescale 1ns/1ps
`include "cbs_consts.svh"
module cbs_ctrl import cbs_pkg::*; #(
  parameter int NBLK = 8,   // Buffers in the block area
  parameter int NBUF = 32,  // Message buffers in total
  parameter int PW   = 3,   // Block pointer width
  parameter int BW   = 5    // Buffer index width
) (
  input  wire logic            i_mclk,          // 40 MHz module clock
  input  wire logic            i_arst_n,        // Async reset, active low
  input  wire logic            i_rx_pin,        // Bus receive pin
  input  wire logic            i_bit_tick,      // Bit sample pulse
  input  wire logic            i_clk_gate_on,   // Module clock supplied
  input  wire logic            i_mode_wr,       // Operating mode write
  input  wire logic [2:0]      i_mode_wdata,    // Requested mode
  input  wire logic            i_ps_wr,         // Power-save field write
  input  wire logic [1:0]      i_ps_wdata,      // Power-save value
  input  wire logic            i_trig_wr,       // Block trigger write
  input  wire logic            i_trig_wdata,    // Block trigger value
  input  wire logic            i_blk_clr,       // Reset block pointer
  input  wire logic [NBLK-1:0] i_buf_ready,     // Block buffers ready
  input  wire logic            i_trq_sw_clr,    // Current request cleared
  input  wire logic            i_frame_active,  // Block frame on the bus
  input  wire logic            i_frame_done,    // Block frame ended
  input  wire logic            i_frame_ok,      // Ended without error
  input  wire logic            i_bus_idle,      // 4th interframe bit recessive
  input  wire logic            i_tx_pending,    // Other requests pending
  input  wire logic            i_msg_storing,   // Frame being stored
  input  wire logic [BW-1:0]   i_tx_sel,        // Buffer chosen to send
  input  wire logic [NBUF-1:0] i_rtr_cfg,       // Remote bit per buffer
  input  wire logic [NBUF-1:0] i_buf_is_tx,     // Transmit buffer flags
  input  wire logic            i_wake_irq_en,   // Wakeup interrupt enable
  input  wire logic            i_wake_clr,      // Clear wakeup flag
  output logic                 o_trigger,       // Block trigger readback
  output logic [PW-1:0]        o_blk_ptr,       // Block pointer
  output logic                 o_blk_tx_req,    // Send block buffer now
  output logic                 o_tx_remote,     // Chosen frame is remote
  output logic [2:0]           o_op_mode,       // Operating mode
  output logic [1:0]           o_ps_field,      // Power-save field
  output logic                 o_clk_run,       // Internal clock enable
  output logic                 o_tx_allow,      // Frame starts permitted
  output logic                 o_reg_wr_allow,  // Non power-save writes
  output logic                 o_hist_rd_allow, // History/pointer reads
  output logic                 o_buf_access_on, // Buffer access flag
  output logic                 o_rx_discard,    // Drop received frame
  output logic                 o_wake_flag,     // Wakeup status flag
  output logic                 o_wake_irq       // Wakeup interrupt
);
  localparam logic [PW-1:0] LAST = PW'(NBLK - 1);

  logic        rst_meta_q;
  logic        rst_n;
  cbs_blk_type blk_q;
  cbs_pw_type  pw_q;
  logic        trq_q;
  logic        abort_q;
  logic        trq_at_abort_q;
  logic        init_pend_q;
  logic        rejoin_q;
  logic        fall;
  logic        idle_run;
  logic        asleep;
  logic        bus_wake;
  logic        sleep_req;
  logic        init_req;
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] ptr_nx;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  // Reset released through two flops
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  cbs_bus_watch u_watch (
    .i_mclk     (i_mclk),
    .i_rst_n    (rst_n),
    .i_rx_pin   (i_rx_pin),
    .i_bit_tick (i_bit_tick),
    .i_restart  (bus_wake || (pw_q == CBS_PW_SLEEP && i_ps_wr && i_ps_wdata == `CBS_PS_AWAKE)), // R22
    .o_fall     (fall),
    .o_idle_run (idle_run)
  );

  assign ptr_nx = next_ptr(ptr_q);
  assign asleep = (pw_q == CBS_PW_SLEEP) || (pw_q == CBS_PW_STOP);
  // Stop ignores the bus; a gated clock keeps the device asleep
  assign bus_wake = (pw_q == CBS_PW_SLEEP) && fall && i_clk_gate_on; // R19 R20
  assign sleep_req = i_ps_wr && (i_ps_wdata == `CBS_PS_SLEEP); // R11
  assign init_req  = i_mode_wr && (i_mode_wdata == `CBS_MODE_INIT);

  // Block engine: trigger, abort and pointer placement
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      blk_q          <= CBS_BLK_IDLE;
      ptr_q          <= '0;
      trq_q          <= 1'b0;
      abort_q        <= 1'b0;
      trq_at_abort_q <= 1'b0;
      o_trigger      <= 1'b0;
    end else begin
      unique case (blk_q)
        CBS_BLK_IDLE: begin
          if (i_blk_clr) begin
            ptr_q <= '0;
          end else if (i_trig_wr && i_trig_wdata && !asleep
                       && o_op_mode == `CBS_MODE_BLOCK) begin
            // Unready buffer: pointer kept, nothing started
            if (i_buf_ready[ptr_q]) begin // R7
              blk_q     <= CBS_BLK_SEND;
              trq_q     <= 1'b1;
              o_trigger <= 1'b1;
            end
          end
        end
        CBS_BLK_SEND: begin
          if (i_trq_sw_clr) begin
            trq_q <= 1'b0;
          end
          if (i_trig_wr && !i_trig_wdata && !abort_q) begin
            if (i_frame_active && !i_frame_done) begin
              abort_q        <= 1'b1; // R1
              trq_at_abort_q <= trq_q && !i_trq_sw_clr;
            end else if (!i_frame_done) begin
              // Nothing on the bus yet: stop at once, same buffer
              blk_q     <= CBS_BLK_IDLE;
              trq_q     <= 1'b0;
              o_trigger <= 1'b0;
            end
          end
          if (i_frame_done && i_frame_ok) begin
            trq_q <= 1'b0;
            ptr_q <= ptr_nx; // R2
            if (ptr_q == LAST || abort_q || !i_buf_ready[ptr_nx]) begin
              // Final buffer done counts as completion even when aborting
              blk_q     <= CBS_BLK_IDLE; // R6
              o_trigger <= 1'b0;
              abort_q   <= 1'b0;
            end else begin
              trq_q <= 1'b1;
            end
          end else if (i_frame_done && abort_q) begin
            // Error: placement depends on request at abort time
            ptr_q     <= trq_at_abort_q ? ptr_q : ptr_nx; // R3 R4
            trq_q     <= 1'b0;
            blk_q     <= CBS_BLK_IDLE;
            o_trigger <= 1'b0; // R1
            abort_q   <= 1'b0;
          end
        end
        default: blk_q <= CBS_BLK_IDLE;
      endcase
    end
  end

  assign o_blk_ptr    = ptr_q;
  // Requests are held, not started, while asleep
  assign o_blk_tx_req = trq_q && !asleep; // R10
  assign o_tx_allow   = !asleep; // R10

  // Remote versus data frame per buffer
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_remote <= 1'b0;
    end else begin
      o_tx_remote <= i_rtr_cfg[i_tx_sel] && i_buf_is_tx[i_tx_sel]; // R8
    end
  end

  // Operating mode; init waits for idle and is refused while asleep
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_op_mode   <= `CBS_MODE_INIT;
      init_pend_q <= 1'b0;
    end else if (!asleep) begin // R14
      if (init_req && o_op_mode != `CBS_MODE_INIT) begin
        init_pend_q <= 1'b1;
      end else if (i_mode_wr && !init_req) begin
        o_op_mode   <= i_mode_wdata;
        init_pend_q <= 1'b0;
      end
      if (init_pend_q && i_bus_idle) begin
        o_op_mode   <= `CBS_MODE_INIT;
        init_pend_q <= 1'b0;
      end
    end
  end

  // Power-save states; the mode register is untouched so release restores it
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pw_q <= CBS_PW_AWAKE;
    end else begin
      unique case (pw_q)
        CBS_PW_AWAKE: begin
          if (sleep_req && !init_req && !init_pend_q
              && o_op_mode != `CBS_MODE_INIT) begin // R14 R16
            pw_q <= CBS_PW_PEND;
          end
        end
        CBS_PW_PEND: begin
          if (init_req || init_pend_q) begin
            pw_q <= CBS_PW_AWAKE; // R16
          end else if (i_ps_wr && i_ps_wdata == `CBS_PS_AWAKE) begin
            pw_q <= CBS_PW_AWAKE;
          end else if (i_bus_idle && !i_tx_pending && !trq_q
                       && !i_msg_storing) begin
            pw_q <= CBS_PW_SLEEP; // R12 R13
          end
        end
        CBS_PW_SLEEP: begin
          if (bus_wake || (i_ps_wr && i_ps_wdata == `CBS_PS_AWAKE)) begin
            pw_q <= CBS_PW_AWAKE; // R19 R9
          end else if (i_ps_wr && i_ps_wdata == `CBS_PS_STOP) begin
            pw_q <= CBS_PW_STOP; // R23
          end
        end
        CBS_PW_STOP: begin
          if (i_ps_wr && i_ps_wdata == `CBS_PS_SLEEP) begin
            pw_q <= CBS_PW_SLEEP;
          end
        end
      endcase
    end
  end

  // Field shows 00 while pending; only a real entry shows 01
  always_comb begin
    unique case (pw_q)
      CBS_PW_SLEEP: o_ps_field = `CBS_PS_SLEEP;
      CBS_PW_STOP:  o_ps_field = `CBS_PS_STOP;
      default:      o_ps_field = `CBS_PS_AWAKE; // R15
    endcase
  end

  // Rejoin wait after release; waking frame is thrown away
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rejoin_q <= 1'b0;
    end else if (pw_q == CBS_PW_SLEEP && (bus_wake || i_ps_wr)) begin
      rejoin_q <= (bus_wake || i_ps_wdata == `CBS_PS_AWAKE); // R22 R20
    end else if (idle_run) begin
      rejoin_q <= 1'b0; // R22
    end
  end

  assign o_rx_discard    = rejoin_q || asleep; // R20
  assign o_clk_run       = !asleep; // R17
  assign o_buf_access_on = !asleep && !rejoin_q; // R17 R22
  assign o_reg_wr_allow  = !asleep; // R18
  assign o_hist_rd_allow = !asleep; // R18

  // Wakeup flag; a new wake beats a clear in the same cycle
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_wake_flag <= 1'b0;
    end else if (bus_wake) begin
      o_wake_flag <= 1'b1; // R21
    end else if (i_wake_clr) begin
      o_wake_flag <= 1'b0;
    end
  end

  assign o_wake_irq = o_wake_flag && i_wake_irq_en; // R24

  // Checks
  sequence abort_on_bus_s;
    blk_q == CBS_BLK_SEND && i_trig_wr && !i_trig_wdata && !abort_q
      && i_frame_active && !i_frame_done;
  endsequence
  sequence err_end_s;
    blk_q == CBS_BLK_SEND && abort_q && i_frame_done && !i_frame_ok;
  endsequence

  trig_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R1
    abort_on_bus_s ##1 (!i_frame_done [*2]) |-> o_trigger)
    else $error("trigger dropped before frame end");
  ptr_ok_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R2
    blk_q == CBS_BLK_SEND && abort_q && i_frame_done && i_frame_ok && ptr_q != LAST
      |=> ptr_q == $past(ptr_q) + 1'b1 && !o_trigger)
    else $error("pointer not advanced after good abort");
  ptr_same_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R3
    err_end_s and trq_at_abort_q |=> $stable(ptr_q) && !o_trigger)
    else $error("pointer moved after error with request set");
  ptr_adv_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R4
    err_end_s and !trq_at_abort_q |=> ptr_q == next_ptr($past(ptr_q)))
    else $error("pointer not advanced after error");
  last_done_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R6
    blk_q == CBS_BLK_SEND && i_frame_done && i_frame_ok && ptr_q == LAST
      |=> ptr_q == '0 && blk_q == CBS_BLK_IDLE)
    else $error("final buffer did not complete block");
  resume_skip_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R7
    blk_q == CBS_BLK_IDLE && !i_blk_clr && i_trig_wr && i_trig_wdata && !i_buf_ready[ptr_q]
      |=> !o_trigger && $stable(ptr_q))
    else $error("resume on unready buffer");
  no_tx_sleep_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R10
    asleep |-> !o_tx_allow && !o_blk_tx_req && !o_buf_access_on)
    else $error("transmission allowed while asleep");
  ps_pend_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R15
    pw_q == CBS_PW_PEND |-> o_ps_field == `CBS_PS_AWAKE)
    else $error("field not 00 while sleep pending");
  init_prio_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R16
    (pw_q != CBS_PW_SLEEP && pw_q != CBS_PW_STOP) && init_req |=> pw_q != CBS_PW_SLEEP)
    else $error("sleep entered over init request");
  wake_flag_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R21
    bus_wake |=> o_wake_flag && pw_q == CBS_PW_AWAKE && o_rx_discard)
    else $error("bus wake did not set flag");
  stop_acc_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R23
    pw_q != CBS_PW_SLEEP && pw_q != CBS_PW_STOP |=> pw_q != CBS_PW_STOP)
    else $error("stop entered from outside sleep");
  wake_irq_a: assert property (@(posedge i_mclk) disable iff (!rst_n) // R24
    o_wake_flag && i_wake_irq_en |-> o_wake_irq)
    else $error("wakeup interrupt missing");
endmodule

// File: include/cbs_consts.svh
// Constants for the block transmit abort and sleep controller.
// Assumes inclusion by bare name from the package and design files.
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH
// Power-save field encodings
`define CBS_PS_AWAKE   2'h0
`define CBS_PS_SLEEP   2'h1
`define CBS_PS_STOP    2'h3
// Operating mode encodings
`define CBS_MODE_INIT  3'h0
`define CBS_MODE_NORM  3'h1
`define CBS_MODE_BLOCK 3'h2
// Recessive bits needed before rejoining the bus
`define CBS_REJOIN_BITS 11
`define CBS_CNT_W       4
`endif

// File: include/cbs_pkg.sv
// Types shared by the controller files.
// Assumes cbs_consts.svh is on the include path.
`include "cbs_consts.svh"
package cbs_pkg;
  typedef enum logic [1:0] {
    CBS_BLK_IDLE = 2'b00,
    CBS_BLK_SEND = 2'b01
  } cbs_blk_type;
  typedef enum logic [1:0] {
    CBS_PW_AWAKE = 2'b00,
    CBS_PW_PEND  = 2'b01,
    CBS_PW_SLEEP = 2'b10,
    CBS_PW_STOP  = 2'b11
  } cbs_pw_type;
endpackage

// File: tb/cbs_bus_node.sv
// Model of the other nodes on the bus: level, bit timing, idle and frames.
// Assumes the bench calls its tasks; everything moves on i_mclk rising edges.
`timescale 1ns/1ps
module cbs_bus_node (
  input  wire logic i_mclk,          // Module clock
  output logic      o_rx_pin,        // Bus level, 1 = recessive
  output logic      o_bit_tick,      // Bit sample pulse
  output logic      o_bus_idle,      // Interframe idle reached
  output logic      o_frame_active,  // Block frame on the bus
  output logic      o_frame_done,    // Frame ended
  output logic      o_frame_ok       // Ended without error
);
  logic [1:0] tick_cnt_q = 2'h0;
  // Four clocks a bit keeps the rejoin wait short
  always_ff @(posedge i_mclk) begin
    tick_cnt_q <= tick_cnt_q + 2'h1;
  end
  assign o_bit_tick = (tick_cnt_q == 2'h3);
  // Bus starts recessive and idle
  initial begin
    o_rx_pin       = 1'b1;
    o_bus_idle     = 1'b1;
    o_frame_active = 1'b0;
    o_frame_done   = 1'b0;
    o_frame_ok     = 1'b0;
  end
  task automatic set_busy(input logic busy);
    @(posedge i_mclk);
    o_bus_idle <= ~busy;
  endtask
  task automatic start_frame();
    @(posedge i_mclk);
    o_bus_idle     <= 1'b0;
    o_frame_active <= 1'b1;
  endtask
  // Outcome qualifier is not held past the done pulse, so it flips
  task automatic end_frame(input logic ok);
    @(posedge i_mclk);
    o_frame_active <= 1'b0;
    o_frame_done   <= 1'b1;
    o_frame_ok     <= ok;
    @(posedge i_mclk);
    o_frame_done <= 1'b0;
    o_frame_ok   <= ~ok;
    o_bus_idle   <= 1'b1;
  endtask
  // Start-of-frame edge held one bit time
  task automatic wake_edge();
    @(posedge i_mclk);
    o_rx_pin <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_rx_pin <= 1'b1;
  endtask
endmodule

// File: tb/cbs_ctrl_bench.sv
// Self-checking bench for the block abort and sleep controller.
// Assumes the bus node model drives the bus-side inputs.
`timescale 1ns/1ps
module cbs_ctrl_bench;
  logic        i_mclk, i_arst_n, i_clk_gate_on, i_mode_wr, i_ps_wr, i_trig_wr, i_trig_wdata;
  logic        i_blk_clr, i_trq_sw_clr, i_tx_pending, i_msg_storing, i_wake_irq_en, i_wake_clr;
  logic        i_rx_pin, i_bit_tick, i_bus_idle, i_frame_active, i_frame_done, i_frame_ok;
  logic [2:0]  i_mode_wdata;
  logic [1:0]  i_ps_wdata;
  logic [7:0]  i_buf_ready;
  logic [4:0]  i_tx_sel;
  logic [31:0] i_rtr_cfg, i_buf_is_tx;
  logic        o_trigger, o_blk_tx_req, o_tx_remote, o_clk_run, o_tx_allow, o_reg_wr_allow;
  logic        o_hist_rd_allow, o_buf_access_on, o_rx_discard, o_wake_flag, o_wake_irq;
  logic [2:0]  o_blk_ptr, o_op_mode;
  logic [1:0]  o_ps_field;
  int          fail_count = 0;
  int          n_checks = 0;
  // Remote select rows: buffer, remote bits, transmit bits, expected
  typedef struct {logic [4:0] sel; logic [31:0] rtr; logic [31:0] tx; logic exp;} cbs_row_type;
  cbs_row_type rows [4] = '{'{5'h03, 32'h8, 32'h8, 1'b1}, '{5'h03, 32'h8, 32'h0, 1'b0},
                           '{5'h03, 32'h0, 32'h8, 1'b0}, '{5'h1f, 32'h80000000, 32'h80000000, 1'b1}};

  cbs_ctrl u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_rx_pin(i_rx_pin), .i_bit_tick(i_bit_tick),
    .i_clk_gate_on(i_clk_gate_on), .i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata),
    .i_ps_wr(i_ps_wr), .i_ps_wdata(i_ps_wdata), .i_trig_wr(i_trig_wr), .i_trig_wdata(i_trig_wdata),
    .i_blk_clr(i_blk_clr), .i_buf_ready(i_buf_ready), .i_trq_sw_clr(i_trq_sw_clr),
    .i_frame_active(i_frame_active), .i_frame_done(i_frame_done), .i_frame_ok(i_frame_ok),
    .i_bus_idle(i_bus_idle), .i_tx_pending(i_tx_pending), .i_msg_storing(i_msg_storing),
    .i_tx_sel(i_tx_sel), .i_rtr_cfg(i_rtr_cfg), .i_buf_is_tx(i_buf_is_tx),
    .i_wake_irq_en(i_wake_irq_en), .i_wake_clr(i_wake_clr), .o_trigger(o_trigger),
    .o_blk_ptr(o_blk_ptr), .o_blk_tx_req(o_blk_tx_req), .o_tx_remote(o_tx_remote),
    .o_op_mode(o_op_mode), .o_ps_field(o_ps_field), .o_clk_run(o_clk_run), .o_tx_allow(o_tx_allow),
    .o_reg_wr_allow(o_reg_wr_allow), .o_hist_rd_allow(o_hist_rd_allow),
    .o_buf_access_on(o_buf_access_on), .o_rx_discard(o_rx_discard), .o_wake_flag(o_wake_flag),
    .o_wake_irq(o_wake_irq));
  cbs_bus_node u_node (.i_mclk(i_mclk), .o_rx_pin(i_rx_pin), .o_bit_tick(i_bit_tick),
    .o_bus_idle(i_bus_idle), .o_frame_active(i_frame_active), .o_frame_done(i_frame_done),
    .o_frame_ok(i_frame_ok));

  // 40 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // One-cycle strobe: 0 mode, 1 power-save, 2 trigger, 3 request clear, 4 wake clear
  task automatic wr(input int k, input logic [2:0] v);
    @(posedge i_mclk);
    case (k)
      0: begin
        i_mode_wr    <= 1'b1;
        i_mode_wdata <= v;
      end
      1: begin
        i_ps_wr    <= 1'b1;
        i_ps_wdata <= v[1:0];
      end
      2: begin
        i_trig_wr    <= 1'b1;
        i_trig_wdata <= v[0];
      end
      3: i_trq_sw_clr <= 1'b1;
      default: i_wake_clr <= 1'b1;
    endcase
    @(posedge i_mclk);
    {i_mode_wr, i_ps_wr, i_trig_wr, i_trq_sw_clr, i_wake_clr} <= 5'h00;
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #(25 * 20000);
    fail_count++;
    end_sim();
  end

  initial begin
    {i_arst_n, i_mode_wr, i_ps_wr, i_trig_wr, i_trig_wdata, i_blk_clr, i_trq_sw_clr} = 7'h00;
    {i_tx_pending, i_msg_storing, i_wake_irq_en, i_wake_clr} = 4'h0;
    {i_clk_gate_on, i_mode_wdata, i_ps_wdata, i_buf_ready, i_tx_sel} = 19'h40000;
    {i_rtr_cfg, i_buf_is_tx} = 64'h0;
    step(5);
    i_arst_n = 1'b1;
    // Reset state
    chk("trigger", o_trigger, 8'h0);
    chk("ptr", o_blk_ptr, 8'h0);
    chk("mode", o_op_mode, 8'h0);
    chk("field", o_ps_field, 8'h0);
    chk("awake", {o_clk_run, o_tx_allow, o_buf_access_on, o_rx_discard, o_wake_flag}, 8'h1c);
    step(2);
    for (int r = 0; r < 4; r++) begin
      @(posedge i_mclk);
      i_tx_sel    <= rows[r].sel;
      i_rtr_cfg   <= rows[r].rtr;
      i_buf_is_tx <= rows[r].tx;
      step(2);
      chk("remote", o_tx_remote, rows[r].exp);
    end
    wr(1, 3'h1);
    step(3);
    chk("init sleep", o_ps_field, 8'h0);
    wr(1, 3'h3);
    chk("stop awake", o_ps_field, 8'h0);
    // Block run, one good frame, then abort during a good frame
    wr(0, 3'h2);
    @(posedge i_mclk);
    i_buf_ready <= 8'hff;
    wr(2, 3'h1);
    chk("trig set", {o_trigger, o_blk_tx_req}, 8'h3);
    u_node.start_frame();
    u_node.end_frame(1'b1);
    step(1);
    chk("ptr ok", o_blk_ptr, 8'h1);
    u_node.start_frame();
    wr(2, 3'h0);
    step(2);
    chk("trig held", o_trigger, 8'h1);
    u_node.end_frame(1'b1);
    step(1);
    chk("abort ok", {o_trigger, o_blk_ptr}, 8'h2);
    // Error with request still set, then with request cleared
    for (int c = 0; c < 2; c++) begin
      wr(2, 3'h1);
      u_node.start_frame();
      if (c == 1) wr(3, 3'h0);
      wr(2, 3'h0);
      u_node.end_frame(1'b0);
      step(1);
      chk("abort err", {o_trigger, o_blk_ptr}, 8'h2 + c[7:0]);
    end
    @(posedge i_mclk);
    i_buf_ready <= 8'hf7;
    wr(2, 3'h1);
    step(1);
    chk("resume unready", {o_trigger, o_blk_ptr}, 8'h3);
    // Engine clear puts the pointer back on the first buffer
    @(posedge i_mclk);
    i_blk_clr <= 1'b1;
    @(posedge i_mclk);
    i_blk_clr <= 1'b0;
    step(1);
    chk("blk clr", o_blk_ptr, 8'h0);
    @(posedge i_mclk);
    i_buf_ready <= 8'hff;
    wr(2, 3'h1);
    repeat (7) begin
      u_node.start_frame();
      u_node.end_frame(1'b1);
    end
    step(1);
    chk("last ptr", o_blk_ptr, 8'h7);
    u_node.start_frame();
    wr(2, 3'h0);
    u_node.end_frame(1'b1);
    step(1);
    chk("last done", {o_trigger, o_blk_ptr}, 8'h0);
    // Sleep held by busy bus, pending transmit, storage
    u_node.set_busy(1'b1);
    @(posedge i_mclk);
    {i_tx_pending, i_msg_storing} <= 2'h3;
    wr(1, 3'h1);
    step(4);
    chk("pend busy", o_ps_field, 8'h0);
    u_node.set_busy(1'b0);
    step(4);
    chk("pend tx", o_ps_field, 8'h0);
    i_tx_pending <= 1'b0;
    step(4);
    chk("pend store", o_ps_field, 8'h0);
    i_msg_storing <= 1'b0;
    step(3);
    chk("asleep", o_ps_field, 8'h1);
    chk("sleep gates", {o_clk_run, o_tx_allow, o_buf_access_on}, 8'h0);
    chk("sleep regs", {o_reg_wr_allow, o_hist_rd_allow}, 8'h0);
    wr(0, 3'h0);
    wr(1, 3'h3);
    chk("stop", o_ps_field, 8'h3);
    wr(1, 3'h1);
    chk("stop exit", o_ps_field, 8'h1);
    u_node.wake_edge();
    step(2);
    chk("woken", {o_ps_field, o_wake_flag, o_wake_irq, o_rx_discard}, 8'h05);
    chk("mode back", o_op_mode, 8'h2);
    i_wake_irq_en <= 1'b1;
    step(1);
    chk("wake irq", o_wake_irq, 8'h1);
    step(20);
    chk("rejoin wait", o_buf_access_on, 8'h0);
    step(60);
    chk("rejoined", {o_buf_access_on, o_rx_discard}, 8'h2);
    wr(1, 3'h0);
    wr(4, 3'h0);
    chk("wake clr", {o_wake_flag, o_wake_irq}, 8'h0);
    // Gated clock: edge keeps sleep, software write releases
    wr(1, 3'h1);
    step(3);
    i_clk_gate_on <= 1'b0;
    u_node.wake_edge();
    step(6);
    chk("gated", o_ps_field, 8'h1);
    i_clk_gate_on <= 1'b1;
    wr(1, 3'h0);
    step(2);
    chk("sw release", {o_ps_field, o_buf_access_on}, 8'h0);
    step(60);
    chk("sw rejoined", o_buf_access_on, 8'h1);
    wr(4, 3'h0);
    // Init pending beats later sleep request
    u_node.set_busy(1'b1);
    wr(0, 3'h0);
    wr(1, 3'h1);
    u_node.set_busy(1'b0);
    step(4);
    chk("init wins", {o_op_mode, o_ps_field}, 8'h0);
    end_sim();
  end
endmodule
